// File: core/bco_burst_order.sv
`timescale 1ns/1ps
// Contract
// - inter-word select 0 gives one clock per word except codes 1011/1101, which give two (1101 is latency 15).
// - ready timing 0 drops the data-ready output in the same cycle invalid data is presented.
// - ready timing 1 drops the data-ready output one cycle before invalid data is presented.
// - async read style resets to 0; 0 is random read, 1 is latch-enable captured read.
// - length code 100 gives one-item bursts and 101 gives two-item bursts on either width.
// - code 001 gives four items, 010 eight words on the 16-bit bus only, 111 continuous unwrapped.
// - the start position is the low one, two or three address bits for lengths two, four, eight.
// - sequential order increments from the start and wraps modulo the burst length.
// - interleaved order is the start position xor a beat counter from zero.
// - an aligned start of zero yields ascending indices in both orders.
// - burst order select 0 means interleaved and 1 means sequential.
// - clock edge select 0 makes the falling edge active and 1 the rising edge.
// - data advances every active clock at latency one and every second at latency two.
// - the latency code sets the clocks from address capture to the first data item.
module bco_burst_order #(
    parameter int ADDR_W     = 23,
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [3:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output wire logic              s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output wire logic              s_axi_wready,
    output logic      [1:0]        s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [3:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output wire logic              s_axi_arready,
    output logic      [31:0]       s_axi_rdata,
    output logic      [1:0]        s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output wire logic              beat_valid,
    input  wire logic              beat_ready,
    output wire logic [ADDR_W-1:0] beat_addr,
    output logic                   valid_data_ready,
    output wire logic              edge_rising,
    output wire logic              latch_read_sel
);
    import bco_pkg::*;

    // latency in clocks for a code, zero when reserved
    function automatic logic [3:0] lat_cycles(input logic [3:0] c);
        case (c)
            4'h2:    lat_cycles = 4'h7;
            4'h3:    lat_cycles = 4'h8;
            4'h4:    lat_cycles = 4'h9;
            4'h5:    lat_cycles = 4'ha;
            4'h6:    lat_cycles = 4'hb;
            4'h9:    lat_cycles = 4'hc;
            4'ha:    lat_cycles = 4'hd;
            4'hb:    lat_cycles = 4'hd;
            4'hd:    lat_cycles = 4'hf;
            default: lat_cycles = 4'h0;
        endcase
    endfunction

    // wrap mask for a length code
    function automatic logic [2:0] len_mask(input logic [2:0] c);
        case (c)
            LEN_2:   len_mask = 3'h1;
            LEN_4:   len_mask = 3'h3;
            LEN_8:   len_mask = 3'h7;
            default: len_mask = 3'h0;
        endcase
    endfunction

    logic [31:0]       config_q;
    logic [ADDR_W-1:0] start_q;
    logic              aw_held, w_held;
    logic [3:0]        aw_addr_q;
    logic [31:0]       w_data_q;
    logic [3:0]        w_strb_q;
    bco_state_e        state;
    logic [3:0]        lat_cnt;
    logic [ADDR_W-1:0] beat_k;
    logic              phase;
    logic              stop_req;

    // configuration fields
    wire [2:0] len_code = config_q[FLD_LEN_LO +: 3];
    wire [3:0] lat_code = config_q[FLD_LAT_LO +: 4];
    wire       iwl_sel  = config_q[FLD_IWL];
    wire       rdy_sel  = config_q[FLD_RDY];
    wire       seq_mode = config_q[FLD_ORDER];
    wire       width32  = config_q[FLD_WIDTH32];
    assign edge_rising    = config_q[FLD_EDGE];
    assign latch_read_sel = config_q[FLD_ASYNC];

    // derived timing and length
    wire       lat_c2   = (lat_code == LAT_C13) || (lat_code == LAT_C15);
    wire       two_clk  = iwl_sel || lat_c2;
    wire [3:0] lat_n    = lat_cycles(lat_code);
    wire       cont     = (len_code == LEN_CONT);
    wire [2:0] mask     = len_mask(len_code);
    wire       len_bad  = !(len_code inside {LEN_1, LEN_2, LEN_4, LEN_8,
                                             LEN_CONT}) ||
                          (width32 && len_code == LEN_8);
    wire       cfg_bad  = len_bad || (lat_n == 4'h0) ||
                          (iwl_sel && lat_c2) || (cont && !seq_mode);

    // beat address generation
    wire [2:0] start_off = start_q[2:0] & mask;
    wire [2:0] k_low     = beat_k[2:0];
    wire [2:0] seq_off   = (start_off + k_low) & mask;
    wire [2:0] ilv_off   = (start_off ^ k_low) & mask;
    wire [2:0] cur_off   = seq_mode ? seq_off : ilv_off;
    wire [ADDR_W-1:0] wrap_addr = (start_q & ~ADDR_W'(mask)) |
                                  ADDR_W'(cur_off);
    wire [ADDR_W-1:0] cont_addr = start_q + beat_k;
    wire [ADDR_W-1:0] next_beat = cont ? cont_addr : wrap_addr;
    wire       last_beat = !cont && (k_low == mask);

    // sequencer handshake with the fifo
    wire       fifo_in_ready;
    wire       beat_fire = (state == ST_RUN) && !phase &&
                           fifo_in_ready;
    wire       pred_fire = ((state == ST_WAIT) && lat_cnt == 4'h1) ||
                           ((state == ST_RUN) && !(beat_fire && last_beat) &&
                            !stop_req && (two_clk ? phase : 1'b1));

    // bus decode
    wire       wr_go    = aw_held && w_held && !s_axi_bvalid;
    wire       rd_go    = s_axi_arvalid && s_axi_arready;
    wire       wr_cfg   = wr_go && aw_addr_q == OFS_CONFIG;
    wire       wr_start = wr_go && aw_addr_q == OFS_START && state == ST_IDLE;
    wire       wr_stop  = wr_go && aw_addr_q == OFS_CTRL &&
                          w_data_q[FLD_STOP];
    wire       wr_map   = aw_addr_q inside {OFS_CONFIG, OFS_START, OFS_CTRL};
    wire [31:0] byte_en = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                           {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    wire [31:0] next_config = ((config_q & ~byte_en) | (w_data_q & byte_en))
                              & CONFIG_MASK;
    wire [31:0] status_word = {28'h0, cfg_bad, stop_req,
                               state == ST_RUN, state != ST_IDLE};
    wire        rd_map = s_axi_araddr inside {OFS_CONFIG, OFS_START,
                                              OFS_STATUS};
    wire [31:0] rd_word = (s_axi_araddr == OFS_CONFIG) ? config_q :
                          (s_axi_araddr == OFS_START)  ? 32'(start_q) :
                          (s_axi_araddr == OFS_STATUS) ? status_word : 32'h0;

    assign s_axi_awready = !aw_held;
    assign s_axi_wready  = !w_held;
    assign s_axi_arready = !s_axi_rvalid;

    // write channel capture and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr_q <= 4'h0;
            w_data_q  <= 32'h0;
            w_strb_q  <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_held) begin
                aw_held   <= 1'b1;
                aw_addr_q <= {s_axi_awaddr[3:2], 2'b00};
            end
            if (s_axi_wvalid && !w_held) begin
                w_held   <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_map ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // configuration and start address registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            config_q <= CONFIG_RESET;
            start_q  <= '0;
        end else begin
            if (wr_cfg)   config_q <= next_config;
            if (wr_start) start_q  <= w_data_q[ADDR_W-1:0];
        end
    end

    // burst sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state    <= ST_IDLE;
            lat_cnt  <= 4'h0;
            beat_k   <= '0;
            phase    <= 1'b0;
            stop_req <= 1'b0;
        end else begin
            if (wr_stop && state != ST_IDLE) stop_req <= 1'b1;
            case (state)
                ST_IDLE: begin
                    stop_req <= 1'b0;
                    if (wr_start && !cfg_bad) begin
                        state   <= ST_WAIT;
                        lat_cnt <= lat_n;
                        beat_k  <= '0;
                        phase   <= 1'b0;
                    end
                end
                ST_WAIT: begin
                    lat_cnt <= lat_cnt - 4'h1;
                    if (lat_cnt == 4'h1) state <= ST_RUN;
                end
                ST_RUN: begin
                    if (stop_req) begin
                        state <= ST_IDLE;
                    end else if (beat_fire) begin
                        beat_k <= beat_k + 1'b1;
                        phase  <= two_clk;
                        if (last_beat) state <= ST_IDLE;
                    end else begin
                        phase <= 1'b0;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // data-ready pin: same cycle or one cycle ahead
    assign valid_data_ready = rdy_sel ? pred_fire : beat_fire;

    bco_fifo #(
        .WIDTH (ADDR_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_valid  (beat_fire),
        .in_ready  (fifo_in_ready),
        .in_data   (next_beat),
        .out_valid (beat_valid),
        .out_ready (beat_ready),
        .out_data  (beat_addr)
    );

    // helper: last fired offset and address, ready history
    logic [2:0]        prev_off;
    logic              prev_pred;
    logic [ADDR_W-1:0] prev_beat;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_off  <= 3'h0;
            prev_pred <= 1'b0;
            prev_beat <= '0;
        end else begin
            prev_pred <= pred_fire;
            if (beat_fire) prev_off <= cur_off;
            if (beat_fire) prev_beat <= next_beat;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    two_clock_gap_a: assert property (beat_fire && two_clk
        |=> !beat_fire)
        else $error("second beat too early");
    one_clock_run_a: assert property (beat_fire && !two_clk
        && !last_beat && fifo_in_ready
        |=> beat_fire || stop_req || !fifo_in_ready)
        else $error("one clock per word broken");
    ready_same_a: assert property (!rdy_sel && valid_data_ready
        && !stop_req |=> beat_k != $past(beat_k))
        else $error("ready not aligned to data");
    ready_ahead_a: assert property (rdy_sel && $stable(rdy_sel)
        && prev_pred && fifo_in_ready && !stop_req |-> beat_fire)
        else $error("ready lead not honoured");
    seq_wrap_a: assert property (beat_fire && seq_mode && !cont
        && k_low != 3'h0 |-> cur_off == ((prev_off + 3'h1) & mask))
        else $error("sequential order wrong");
    ilv_xor_a: assert property (beat_fire && !seq_mode
        && k_low != 3'h0
        |-> (cur_off ^ prev_off) == ((k_low ^ (k_low - 3'h1)) & mask))
        else $error("interleaved order wrong");
    zero_start_a: assert property (beat_fire && !cont
        && start_off == 3'h0 |-> cur_off == (k_low & mask))
        else $error("aligned burst not ascending");
    first_latency_a: assert property ($rose(state == ST_WAIT)
        && lat_n == 4'h8 |-> (state == ST_WAIT) [*8] ##1 state == ST_RUN)
        else $error("first access latency wrong");
    cont_linear_a: assert property (beat_fire && cont
        && beat_k != '0 |-> next_beat == prev_beat + ADDR_W'(1))
        else $error("continuous not linear");
    async_reset_a: assert property ($rose(aresetn)
        |-> !latch_read_sel) else $error("async style not reset");

    burst8_c: cover property (beat_fire && len_code == LEN_8 && last_beat);
    cont_stop_c: cover property (stop_req && state == ST_RUN);
    ready_lead_c: cover property (rdy_sel && pred_fire && !beat_fire);
    fifo_full_c: cover property (state == ST_RUN && !fifo_in_ready);
endmodule // bco_burst_order

// File: core/bco_pkg.sv
package bco_pkg;
    // register byte offsets
    localparam logic [3:0] OFS_CONFIG = 4'h0;
    localparam logic [3:0] OFS_START  = 4'h4;
    localparam logic [3:0] OFS_CTRL   = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hc;
    // config field positions
    localparam int FLD_LEN_LO   = 0;  // burst_length_code [2:0]
    localparam int FLD_ASYNC    = 3;  // async_read_style
    localparam int FLD_EDGE     = 6;  // clock_edge_sel
    localparam int FLD_ORDER    = 7;  // burst_order_sel
    localparam int FLD_RDY      = 8;  // ready_timing_sel
    localparam int FLD_IWL      = 9;  // inter_word_latency_sel
    localparam int FLD_LAT_LO   = 11; // first_access_latency_code [14:11]
    localparam int FLD_WIDTH32  = 16; // bus organised as double-words
    localparam int FLD_STOP     = 0;  // control: end a continuous burst
    // config value after reset
    localparam logic [31:0] CONFIG_RESET = 32'h0000_18c1;
    localparam logic [31:0] CONFIG_MASK  = 32'h0001_7bcf;
    // burst length codes
    localparam logic [2:0] LEN_1    = 3'h4;
    localparam logic [2:0] LEN_2    = 3'h5;
    localparam logic [2:0] LEN_4    = 3'h1;
    localparam logic [2:0] LEN_8    = 3'h2;
    localparam logic [2:0] LEN_CONT = 3'h7;
    // latency codes that force two clocks per word
    localparam logic [3:0] LAT_C13 = 4'hb;
    localparam logic [3:0] LAT_C15 = 4'hd;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_RUN  = 2'b10
    } bco_state_e;
endpackage

// File: core/bco_fifo.sv
`timescale 1ns/1ps
// small synchronous fifo, valid/ready on both sides
module bco_fifo #(
    parameter int WIDTH = 23,
    parameter int DEPTH = 8
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             in_valid,
    output wire logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output wire logic             out_valid,
    input  wire logic             out_ready,
    output wire logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    // honest full and empty
    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];

    // storage, no reset needed
    always_ff @(posedge aclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and fill level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            if (pop)  rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    fifo_no_over_a: assert property (@(posedge aclk) disable iff (!aresetn)
        count <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule // bco_fifo

// File: testbench/bco_beat_sink.sv
`timescale 1ns/1ps
// beat consumer in place of the host memory controller
module bco_beat_sink (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        beat_valid,
    output logic             beat_ready,
    input  wire logic [22:0] beat_addr,
    input  wire logic [1:0]  mode,
    input  wire logic        data_ready
);
    logic [22:0] got_addr[$];
    int          got_cyc[$];
    int          vdr_cyc[$];
    int          cyc = 0;

    // ready pattern: 0 prompt, 1 stalled, 2 every other cycle
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (!aresetn) begin
            beat_ready <= 1'b0;
        end else begin
            beat_ready <= (mode == 2'd0) || (mode == 2'd2 && !beat_ready);
        end
        // record each accepted address with its cycle
        if (aresetn && beat_valid && beat_ready) begin
            got_addr.push_back(beat_addr);
            got_cyc.push_back(cyc);
        end
        // record each cycle with the data-ready pin high
        if (aresetn && data_ready) vdr_cyc.push_back(cyc);
    end
endmodule // bco_beat_sink

// File: testbench/tb_burst_config_and_address_order.sv
`timescale 1ns/1ps
module tb_burst_config_and_address_order;
    import bco_pkg::*;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [3:0]  awaddr = 4'h0;
    logic [3:0]  araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic [1:0]  mode = 2'd0;
    wire logic   awready, wready, bvalid, arready, rvalid;
    wire logic   beat_valid, beat_ready, vdr, edge_r, latch_r;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [22:0] beat_addr;
    int          error_cnt = 0;
    int          checks = 0;

    // 125 mhz clock
    always #4 aclk = ~aclk;

    bco_burst_order #(.ADDR_W(23), .FIFO_DEPTH(8)) i_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .beat_valid(beat_valid), .beat_ready(beat_ready),
        .beat_addr(beat_addr), .valid_data_ready(vdr),
        .edge_rising(edge_r), .latch_read_sel(latch_r)
    );

    bco_beat_sink i_sink (
        .aclk(aclk), .aresetn(aresetn), .beat_valid(beat_valid),
        .beat_ready(beat_ready), .beat_addr(beat_addr), .mode(mode),
        .data_ready(vdr)
    );

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // one axi write: address and data together, wait for response
    task automatic wr(input logic [3:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        bit aw_ok;
        bit w_ok;
        int n;
        aw_ok = 0;
        w_ok = 0;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok) && n < 100) begin
            @(posedge aclk);
            n++;
            if (!aw_ok && awready) begin
                aw_ok = 1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1;
                wvalid <= 1'b0;
            end
        end
        while (!bvalid && n < 100) begin
            @(posedge aclk);
            n++;
        end
        r = bresp;
        bready <= 1'b0;
        chk("write answered", 1, n < 100);
    endtask

    // one axi read
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && !arvalid) && n < 100);
        d = rdata;
        rready <= 1'b0;
        chk("read answered", 1, n < 100);
    endtask

    function automatic logic [31:0] cf(input logic [2:0] len,
        input logic ord, input logic iw, input logic [3:0] lat);
        cf = 32'h40 | {17'h0, lat, 1'b0, iw, 1'b0, ord, 1'b0, 3'h0, len};
    endfunction

    task automatic t_reset();
        logic [31:0] d;
        logic [1:0]  r;
        rd(OFS_CONFIG, d);
        chk("config reset", CONFIG_RESET, d);
        chk("edge_rising reset", 1, edge_r);
        chk("latch_read_sel reset", 0, latch_r);
        chk("valid_data_ready idle", 0, vdr);
        wr(OFS_STATUS, 32'h1, r);
        chk("status write resp", RESP_SLVERR, r);
        wr(OFS_CONFIG, 32'h8, r);
        tick(2);
        chk("edge_rising falling", 0, edge_r);
        chk("latch_read_sel set", 1, latch_r);
        rd(OFS_CONFIG, d);
        chk("config readback", 32'h8 & CONFIG_MASK, d);
    endtask

    // run one burst and compare the address order and spacing
    task automatic burst(input logic [31:0] c, input logic [22:0] a,
                         input int len, input int gap, input bit stall);
        logic [1:0]  r;
        logic [22:0] m;
        logic [22:0] e;
        int n;
        int lead;
        int dv;
        bit pin_ok;
        m = 23'(len - 1);
        lead = c[FLD_RDY] ? 2 : 1;
        pin_ok = (len <= 8) && !stall;
        wr(OFS_CONFIG, c, r);
        i_sink.got_addr.delete();
        i_sink.got_cyc.delete();
        i_sink.vdr_cyc.delete();
        mode <= stall ? 2'd1 : 2'd0;
        wr(OFS_START, {9'h0, a}, r);
        if (stall) begin
            tick(60);
            chk("beat held while stalled", 1, beat_valid);
            chk("nothing taken while stalled", 0, i_sink.got_addr.size());
            mode <= 2'd2;
        end
        n = 0;
        while (i_sink.got_addr.size() < len && n < 400) begin
            tick(1);
            n++;
        end
        if (len > 8) wr(OFS_CTRL, 32'h1, r);
        tick(30);
        if (len <= 8) chk("beat count", len, i_sink.got_addr.size());
        if (pin_ok)
            chk("ready count", len, i_sink.vdr_cyc.size());
        for (int k = 0; k < len; k++) begin
            if (pin_ok) begin
                dv = i_sink.got_cyc[k] - i_sink.vdr_cyc[k];
                chk("ready lead", lead, dv);
            end
            if (len > 8) e = a + 23'(k);
            else if (c[FLD_ORDER]) e = (a & ~m) | ((a + 23'(k)) & m);
            else e = (a & ~m) | ((a ^ 23'(k)) & m);
            chk("beat address", {9'h0, e}, {9'h0, i_sink.got_addr[k]});
            if (gap > 0 && k > 0)
                chk("beat gap", gap,
                    i_sink.got_cyc[k] - i_sink.got_cyc[k-1]);
        end
        mode <= 2'd0;
    endtask

    task automatic t_invalid();
        logic [31:0] c[4];
        logic [31:0] d;
        logic [1:0]  r;
        c = '{cf(LEN_4, 1, 1, LAT_C15), cf(LEN_CONT, 0, 0, 4'h3),
              cf(3'h3, 1, 0, 4'h3), cf(LEN_8, 1, 0, 4'h3) | 32'h10000};
        foreach (c[i]) begin
            wr(OFS_CONFIG, c[i], r);
            rd(OFS_STATUS, d);
            chk("config invalid flag", 1, d[3]);
            i_sink.got_addr.delete();
            wr(OFS_START, 32'h10, r);
            tick(40);
            chk("no beats", 0, i_sink.got_addr.size());
        end
    endtask

    task automatic conclude();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        tick(4);
        aresetn <= 1'b1;
        t_reset();
        burst(cf(LEN_8, 1, 0, 4'h3), 23'h1231, 8, 1, 0);
        burst(cf(LEN_8, 0, 0, 4'h3), 23'h1235, 8, 0, 1);
        burst(cf(LEN_4, 1, 0, 4'h3), 23'h1230, 4, 1, 0);
        burst(cf(LEN_4, 0, 0, LAT_C15), 23'h1230, 4, 2, 0);
        burst(cf(LEN_4, 1, 1, 4'h3), 23'h1236, 4, 2, 0);
        burst(cf(LEN_2, 0, 0, 4'h3), 23'h1233, 2, 1, 0);
        burst(cf(LEN_1, 1, 0, 4'h3), 23'h1237, 1, 0, 0);
        burst(cf(LEN_8, 1, 0, 4'h3) | 32'h100, 23'h1234, 8, 1, 0);
        burst(cf(LEN_4, 0, 1, 4'h4) | 32'h100, 23'h1231, 4, 2, 0);
        burst(cf(LEN_CONT, 1, 0, LAT_C13), 23'h12fe, 12, 2, 0);
        t_invalid();
        conclude();
    end

    // watchdog against a hung handshake
    initial begin
        #200000;
        error_cnt++;
        conclude();
    end
endmodule // tb_burst_config_and_address_order
